/* hw/amp_ctrl_map.svh */
// register offsets, field positions, reset values and timing in nanoseconds
`ifndef AMP_CTRL_MAP_SVH
`define AMP_CTRL_MAP_SVH

// seven-bit bus address, byte 8'hb0 write / 8'hb1 read
`define AMP_SLAVE_ADDR      7'h58

// register indexes
`define AMP_IDX_FUNC        8'h01
`define AMP_IDX_ATTACK      8'h02
`define AMP_IDX_RELEASE     8'h03
`define AMP_IDX_HOLD        8'h04
`define AMP_IDX_GAIN        8'h05
`define AMP_IDX_LIMIT       8'h06
`define AMP_IDX_MAXGAIN     8'h07

// function control field positions
`define AMP_BIT_EN_R        7
`define AMP_BIT_EN_L        6
`define AMP_BIT_SWS         5
`define AMP_BIT_FAULT_R     4
`define AMP_BIT_FAULT_L     3
`define AMP_BIT_THERMAL     2
`define AMP_BIT_ONE         1
`define AMP_BIT_NOISE_GATE_ENABLE       0

// reset values
`define AMP_RST_FUNC        8'hc3
`define AMP_RST_ATTACK      8'h05
`define AMP_RST_RELEASE     8'h0b
`define AMP_RST_HOLD        8'h00
`define AMP_RST_GAIN        8'h06
`define AMP_RST_LIMIT       8'h3a
`define AMP_RST_MAXGAIN     8'hc2

// unmapped index read value
`define AMP_RD_UNMAPPED     8'h00

// timing: clock period and overtemperature deglitch time
`define AMP_CLK_PERIOD_NS   10
`define AMP_DEGLITCH_NS     1000

`endif

/* hw/amp_ctrl_pkg.sv */
// types shared by the amplifier control register port
package amp_ctrl_pkg;

    // serial slave protocol states
    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INDEX,
        ST_INDEX_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } slave_state_t;

endpackage

/* hw/amp_control_register_port.sv */
// two-wire slave register port and control bank of a stereo amplifier
`timescale 1ns/1ps
`include "amp_ctrl_map.svh"

module amp_control_register_port
(
    // clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_RST_N,
    // serial bus pins
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output logic            O_SDA,
    output logic            O_SDA_OE,
    // protection inputs
    input  wire logic       I_SHORT_R,
    input  wire logic       I_SHORT_L,
    input  wire logic       I_OVER_TEMP,
    // amplifier controls
    output logic            O_RIGHT_AMP_ON,
    output logic            O_LEFT_AMP_ON,
    output logic            O_SHUTDOWN,
    output logic            O_NOISE_GATE_EN,
    output logic [5:0]      O_ATTACK_TIME,
    output logic [5:0]      O_RELEASE_TIME,
    output logic [5:0]      O_HOLD_TIME,
    output logic [5:0]      O_FIXED_GAIN,
    output logic [7:0]      O_LIMITER_CTRL,
    output logic [7:0]      O_MAX_GAIN_CTRL
);

    // ********************************
    // declarations
    // ********************************
    localparam int DEGLITCH_CYC =
        (`AMP_DEGLITCH_NS + `AMP_CLK_PERIOD_NS - 1) / `AMP_CLK_PERIOD_NS;

    logic [1:0]                 rst_sync_ff;
    logic                       rst_n;
    logic                       scl_d_ff;
    logic                       sda_d_ff;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       bus_start;
    logic                       bus_stop;
    amp_ctrl_pkg::slave_state_t state_ff;
    logic [3:0]                 bit_cnt_ff;
    logic [7:0]                 shift_ff;
    logic [7:0]                 index_ff;
    logic [7:0]                 nxt_index;
    logic                       rw_ff;
    logic                       nack_ff;
    logic                       sda_oe_ff;
    logic                       sda_out_ff;
    logic                       byte_done;
    logic                       wr_en;
    logic [7:0]                 rd_cur;
    logic [7:0]                 rd_nxt;
    logic [7:0]                 func_ff;
    logic [5:0]                 attack_ff;
    logic [5:0]                 release_ff;
    logic [5:0]                 hold_ff;
    logic [5:0]                 gain_ff;
    logic [7:0]                 limit_ff;
    logic [7:0]                 maxgain_ff;
    logic [6:0]                 hot_cnt_ff;
    logic                       hot_ff;
    logic                       amp_r_ff;
    logic                       amp_l_ff;

    // ********************************
    // reset release
    // ********************************
    // two-stage release of the asynchronous reset
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // ********************************
    // bus line events
    // ********************************
    // previous line levels for edge and condition detection
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= I_SCL;
            sda_d_ff <= I_SDA;
        end
    end

    // start and stop are data edges while the clock line is high
    assign scl_rise  = I_SCL && !scl_d_ff;
    assign scl_fall  = !I_SCL && scl_d_ff;
    assign bus_start = I_SCL && scl_d_ff && sda_d_ff && !I_SDA;
    assign bus_stop  = I_SCL && scl_d_ff && !sda_d_ff && I_SDA;
    assign byte_done = scl_fall && (bit_cnt_ff == 4'h8);
    assign nxt_index = index_ff + 8'h01;

    // ********************************
    // register read path
    // ********************************
    // reserved reads
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [7:0] val;
        val = `AMP_RD_UNMAPPED;
        case (idx)
            `AMP_IDX_FUNC:    val = func_ff;
            `AMP_IDX_ATTACK:  val = {2'h0, attack_ff};
            `AMP_IDX_RELEASE: val = {2'h0, release_ff};
            `AMP_IDX_HOLD:    val = {2'h0, hold_ff};
            `AMP_IDX_GAIN:    val = {2'h0, gain_ff};
            `AMP_IDX_LIMIT:   val = limit_ff;
            `AMP_IDX_MAXGAIN: val = {maxgain_ff[7:4], 2'h0, maxgain_ff[1:0]};
            default:          val = `AMP_RD_UNMAPPED;
        endcase
        return val;
    endfunction

    // current and next readback, re-evaluated whenever a register moves
    always_comb
    begin
        rd_cur = rd_byte(index_ff);
        rd_nxt = rd_byte(nxt_index);
    end
    assign wr_en  = byte_done && (state_ff == amp_ctrl_pkg::ST_WDATA);

    // ********************************
    // slave protocol engine
    // ********************************
    // byte framing, acknowledge drive and index stepping
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff   <= amp_ctrl_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            index_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            nack_ff    <= 1'b1;
            sda_oe_ff  <= 1'b0;
        end
        else if (bus_start)
        begin
            state_ff   <= amp_ctrl_pkg::ST_ADDR;
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_ff  <= amp_ctrl_pkg::ST_IDLE;
            sda_oe_ff <= 1'b0;
        end
        else if (scl_rise)
        begin
            unique case (state_ff)
                amp_ctrl_pkg::ST_ADDR,
                amp_ctrl_pkg::ST_INDEX,
                amp_ctrl_pkg::ST_WDATA:
                begin
                    shift_ff   <= {shift_ff[6:0], I_SDA};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                amp_ctrl_pkg::ST_RDATA:
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                amp_ctrl_pkg::ST_RACK:
                    nack_ff <= I_SDA;
                amp_ctrl_pkg::ST_IDLE,
                amp_ctrl_pkg::ST_ADDR_ACK,
                amp_ctrl_pkg::ST_INDEX_ACK,
                amp_ctrl_pkg::ST_WDATA_ACK:
                    nack_ff <= nack_ff;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (state_ff)
                amp_ctrl_pkg::ST_ADDR:
                    if (bit_cnt_ff == 4'h8)
                    begin
                        bit_cnt_ff <= 4'h0;
                        if (shift_ff[7:1] == `AMP_SLAVE_ADDR)
                        begin
                            state_ff  <= amp_ctrl_pkg::ST_ADDR_ACK;
                            rw_ff     <= shift_ff[0];
                            sda_oe_ff <= 1'b1;
                        end
                        else
                            state_ff <= amp_ctrl_pkg::ST_IDLE;
                    end
                amp_ctrl_pkg::ST_INDEX:
                    if (bit_cnt_ff == 4'h8)
                    begin
                        bit_cnt_ff <= 4'h0;
                        index_ff   <= shift_ff;
                        state_ff   <= amp_ctrl_pkg::ST_INDEX_ACK;
                        sda_oe_ff  <= 1'b1;
                    end
                amp_ctrl_pkg::ST_WDATA:
                    if (bit_cnt_ff == 4'h8)
                    begin
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= amp_ctrl_pkg::ST_WDATA_ACK;
                        sda_oe_ff  <= 1'b1;
                    end
                amp_ctrl_pkg::ST_ADDR_ACK:
                    if (rw_ff)
                    begin
                        shift_ff  <= rd_cur;
                        sda_oe_ff <= !rd_cur[7];
                        state_ff  <= amp_ctrl_pkg::ST_RDATA;
                    end
                    else
                    begin
                        sda_oe_ff <= 1'b0;
                        state_ff  <= amp_ctrl_pkg::ST_INDEX;
                    end
                amp_ctrl_pkg::ST_INDEX_ACK:
                begin
                    sda_oe_ff <= 1'b0;
                    state_ff  <= amp_ctrl_pkg::ST_WDATA;
                end
                amp_ctrl_pkg::ST_WDATA_ACK:
                begin
                    sda_oe_ff <= 1'b0;
                    index_ff  <= nxt_index;
                    state_ff  <= amp_ctrl_pkg::ST_WDATA;
                end
                amp_ctrl_pkg::ST_RDATA:
                    if (bit_cnt_ff == 4'h8)
                    begin
                        bit_cnt_ff <= 4'h0;
                        sda_oe_ff  <= 1'b0;
                        state_ff   <= amp_ctrl_pkg::ST_RACK;
                    end
                    else
                    begin
                        sda_oe_ff <= !shift_ff[6];
                        shift_ff  <= {shift_ff[6:0], 1'b0};
                    end
                amp_ctrl_pkg::ST_RACK:
                begin
                    index_ff <= nxt_index;
                    if (!nack_ff)
                    begin
                        shift_ff  <= rd_nxt;
                        sda_oe_ff <= !rd_nxt[7];
                        state_ff  <= amp_ctrl_pkg::ST_RDATA;
                    end
                    else
                        state_ff <= amp_ctrl_pkg::ST_IDLE;
                end
                amp_ctrl_pkg::ST_IDLE:
                    sda_oe_ff <= 1'b0;
            endcase
        end
    end

    // line value is always low; the enable does the driving
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            sda_out_ff <= 1'b0;
        else
            sda_out_ff <= 1'b0;
    end

    // ********************************
    // function control register
    // ********************************
    // layout with sticky flags; a set wins over a clear
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            func_ff <= `AMP_RST_FUNC;
        else
        begin
            if (wr_en && index_ff == `AMP_IDX_FUNC)
            begin
                func_ff[`AMP_BIT_EN_R]    <= shift_ff[`AMP_BIT_EN_R];
                func_ff[`AMP_BIT_EN_L]    <= shift_ff[`AMP_BIT_EN_L];
                func_ff[`AMP_BIT_SWS]     <= shift_ff[`AMP_BIT_SWS];
                func_ff[`AMP_BIT_NOISE_GATE_ENABLE]   <= shift_ff[`AMP_BIT_NOISE_GATE_ENABLE];
                func_ff[`AMP_BIT_FAULT_R] <= func_ff[`AMP_BIT_FAULT_R]
                                             && shift_ff[`AMP_BIT_FAULT_R];
                func_ff[`AMP_BIT_FAULT_L] <= func_ff[`AMP_BIT_FAULT_L]
                                             && shift_ff[`AMP_BIT_FAULT_L];
                func_ff[`AMP_BIT_THERMAL] <= func_ff[`AMP_BIT_THERMAL]
                                             && shift_ff[`AMP_BIT_THERMAL];
            end
            func_ff[`AMP_BIT_ONE] <= 1'b1;
            if (I_SHORT_R)
                func_ff[`AMP_BIT_FAULT_R] <= 1'b1;
            if (I_SHORT_L)
                func_ff[`AMP_BIT_FAULT_L] <= 1'b1;
            if (hot_ff)
                func_ff[`AMP_BIT_THERMAL] <= 1'b1;
        end
    end

    // ********************************
    // gain control registers
    // ********************************
    // six-bit timing and gain fields; eight-bit limiter and max gain fields
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attack_ff  <= 6'(`AMP_RST_ATTACK);
            release_ff <= 6'(`AMP_RST_RELEASE);
            hold_ff    <= 6'(`AMP_RST_HOLD);
            gain_ff    <= 6'(`AMP_RST_GAIN);
            limit_ff   <= `AMP_RST_LIMIT;
            maxgain_ff <= `AMP_RST_MAXGAIN;
        end
        else if (wr_en)
        begin
            case (index_ff)
                `AMP_IDX_ATTACK:  attack_ff  <= shift_ff[5:0];
                `AMP_IDX_RELEASE: release_ff <= shift_ff[5:0];
                `AMP_IDX_HOLD:    hold_ff    <= shift_ff[5:0];
                `AMP_IDX_GAIN:    gain_ff    <= shift_ff[5:0];
                `AMP_IDX_LIMIT:   limit_ff   <= shift_ff;
                `AMP_IDX_MAXGAIN: maxgain_ff <= {shift_ff[7:4], 2'h0,
                                                 shift_ff[1:0]};
                default:          limit_ff   <= limit_ff;
            endcase
        end
    end

    // ********************************
    // thermal deglitch and amplifier gating
    // ********************************
    // overtemperature deglitch
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hot_cnt_ff <= 7'h00;
            hot_ff     <= 1'b0;
        end
        else if (!I_OVER_TEMP)
        begin
            hot_cnt_ff <= 7'h00;
            hot_ff     <= 1'b0;
        end
        else if (hot_cnt_ff == 7'(DEGLITCH_CYC - 1))
            hot_ff <= 1'b1;
        else
            hot_cnt_ff <= hot_cnt_ff + 7'h01;
    end

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            amp_r_ff <= 1'b0;
            amp_l_ff <= 1'b0;
        end
        else
        begin
            amp_r_ff <= func_ff[`AMP_BIT_EN_R] && !hot_ff
                        && !func_ff[`AMP_BIT_SWS];
            amp_l_ff <= func_ff[`AMP_BIT_EN_L] && !hot_ff
                        && !func_ff[`AMP_BIT_SWS];
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign O_SDA           = sda_out_ff;
    assign O_SDA_OE        = sda_oe_ff;
    assign O_RIGHT_AMP_ON  = amp_r_ff;
    assign O_LEFT_AMP_ON   = amp_l_ff;
    assign O_SHUTDOWN      = func_ff[`AMP_BIT_SWS];
    assign O_NOISE_GATE_EN = func_ff[`AMP_BIT_NOISE_GATE_ENABLE];
    assign O_ATTACK_TIME   = attack_ff;
    assign O_RELEASE_TIME  = release_ff;
    assign O_HOLD_TIME     = hold_ff;
    assign O_FIXED_GAIN    = gain_ff;
    assign O_LIMITER_CTRL  = limit_ff;
    assign O_MAX_GAIN_CTRL = maxgain_ff;

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_addr_end;
        state_ff == amp_ctrl_pkg::ST_ADDR && byte_done;
    endsequence
    sequence s_index_end;
        state_ff == amp_ctrl_pkg::ST_INDEX && byte_done && !bus_start
        && !bus_stop;
    endsequence

    property p_addr_ack;
        s_addr_end ##0 (shift_ff[7:1] == `AMP_SLAVE_ADDR) && !bus_start
        |=> state_ff == amp_ctrl_pkg::ST_ADDR_ACK && sda_oe_ff;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("no addr ack");

    property p_index;
        s_index_end |=> index_ff == $past(shift_ff) && sda_oe_ff;
    endproperty
    a_index: assert property (p_index)
        else $error("index not taken");

    property p_read_load;
        state_ff == amp_ctrl_pkg::ST_ADDR_ACK && scl_fall && rw_ff
        && !bus_start && !bus_stop
        |=> shift_ff == $past(rd_cur) && state_ff == amp_ctrl_pkg::ST_RDATA;
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("bad read");

    property p_seq_read;
        state_ff == amp_ctrl_pkg::ST_RACK && scl_fall && !nack_ff
        && !bus_start && !bus_stop
        |=> state_ff == amp_ctrl_pkg::ST_RDATA
            && index_ff == $past(index_ff) + 8'h01;
    endproperty
    a_seq_read: assert property (p_seq_read)
        else $error("no next byte");

    property p_wr_step;
        state_ff == amp_ctrl_pkg::ST_WDATA_ACK && scl_fall && !bus_start
        && !bus_stop |=> index_ff == $past(index_ff) + 8'h01;
    endproperty
    a_wr_step: assert property (p_wr_step)
        else $error("no index step");

    property p_fault_r;
        I_SHORT_R |=> func_ff[`AMP_BIT_FAULT_R] ##1
            func_ff[`AMP_BIT_FAULT_R] || $past(wr_en);
    endproperty
    a_fault_r: assert property (p_fault_r)
        else $error("fault r lost");

    property p_fault_l;
        I_SHORT_L |=> func_ff[`AMP_BIT_FAULT_L];
    endproperty
    a_fault_l: assert property (p_fault_l)
        else $error("fault l lost");

    property p_thermal;
        hot_ff |=> func_ff[`AMP_BIT_THERMAL];
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("no thermal");

    property p_deglitch;
        !I_OVER_TEMP |=> !hot_ff;
    endproperty
    a_deglitch: assert property (p_deglitch)
        else $error("glitch passed");

    property p_gate;
        hot_ff || func_ff[`AMP_BIT_SWS]
        |=> !O_RIGHT_AMP_ON && !O_LEFT_AMP_ON;
    endproperty
    a_gate: assert property (p_gate)
        else $error("amp not gated");

    property p_one;
        index_ff == `AMP_IDX_FUNC |-> rd_cur[`AMP_BIT_ONE];
    endproperty
    a_one: assert property (p_one)
        else $error("bit1 not one");

endmodule

/* tb/amp_bus_master.sv */
// behavioural two-wire bus master for the amplifier port
`timescale 1ns/1ps
module amp_bus_master
(
    // clock
    input  wire logic i_clk,
    // device pull-down
    input  wire logic i_dev_oe,
    // bus lines
    output logic      o_scl,
    output logic      o_sda
);
    logic drv_low = 1'b0;
    // open-drain data line with pull-up
    assign o_sda = !(drv_low || i_dev_oe);
    // clock line idles high
    initial o_scl = 1'b1;
    // wait n cycles, then change just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // start or repeated start from any line state
    task automatic start();
        drv_low = 1'b0;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        drv_low = 1'b1;
        tick(4);
        o_scl = 1'b0;
        tick(4);
    endtask
    // stop: data rises while clock high
    task automatic stop();
        drv_low = 1'b1;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        drv_low = 1'b0;
        tick(4);
    endtask
    // byte msb first plus ack clock; ff releases line
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] q, output logic r);
        for (int i = 7; i >= -1; i--)
        begin
            drv_low = (i >= 0) ? !d[i] : !a;
            tick(4);
            o_scl = 1'b1;
            tick(4);
            if (i >= 0)
                q[i] = o_sda;
            else
                r = o_sda;
            tick(4);
            o_scl = 1'b0;
            tick(4);
        end
    endtask
endmodule

/* tb/amp_control_register_port_tb.sv */
// self-checking bench for the amplifier control register port
`timescale 1ns/1ps
module amp_control_register_port_tb;
    logic       clk;
    logic       rst_n;
    logic       sh_r;
    logic       sh_l;
    logic       hot;
    logic       scl, sda, sda_o, oe, am_r, am_l, sd, ng, r;
    logic [5:0] atk, rel, hld, gn;
    logic [7:0] lim, mxg, q;
    int         num_errors = 0;
    int         num_checks = 0;
    int         cycles = 0;
    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;
    amp_control_register_port uut
    (
        .I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda),
        .O_SDA(sda_o), .O_SDA_OE(oe), .I_SHORT_R(sh_r),
        .I_SHORT_L(sh_l), .I_OVER_TEMP(hot), .O_RIGHT_AMP_ON(am_r),
        .O_LEFT_AMP_ON(am_l), .O_SHUTDOWN(sd), .O_NOISE_GATE_EN(ng),
        .O_ATTACK_TIME(atk), .O_RELEASE_TIME(rel), .O_HOLD_TIME(hld),
        .O_FIXED_GAIN(gn), .O_LIMITER_CTRL(lim), .O_MAX_GAIN_CTRL(mxg)
    );
    amp_bus_master m
    (
        .i_clk(clk), .i_dev_oe(oe), .o_scl(scl), .o_sda(sda)
    );
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // address for write, then the register index
    task automatic setidx(input logic [7:0] idx);
        m.start();
        m.xfer(8'hb0, 1'b1, q, r);
        chk(r, 16'h0);
        m.xfer(idx, 1'b1, q, r);
        chk(r, 16'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
        setidx(idx);
        foreach (d[i])
            m.xfer(d[i], 1'b1, q, r);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
        setidx(idx);
        m.start();
        m.xfer(8'hb1, 1'b1, q, r);
        chk(r, 16'h0);
        foreach (e[i])
        begin
            m.xfer(8'hff, i == e.size() - 1, q, r);
            chk(q, e[i]);
        end
        m.stop();
    endtask
    // cycle ceiling against a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        sh_r  = 1'b0;
        sh_l  = 1'b0;
        hot   = 1'b0;
        m.tick(20);
        rst_n = 1'b1;
        m.tick(5);
        chk({am_r, am_l, sd, ng}, 16'hd);
        chk(sda_o, 16'h0);
        rd(8'h01, {8'hc3, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h3a,
                   8'hc2});
        m.start();
        m.xfer(8'hb2, 1'b1, q, r);
        chk(r, 16'h1);
        m.stop();
        wr(8'h02, {8'hff, 8'hff, 8'hff, 8'hff, 8'h95, 8'h9d});
        chk({2'b0, atk, 2'b0, rel}, 16'h3f3f);
        chk({2'b0, hld, 2'b0, gn}, 16'h3f3f);
        chk({lim, mxg}, 16'h9591);
        rd(8'h02, {8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h95, 8'h91});
        wr(8'h01, {8'hff});
        chk({am_r, am_l, sd, ng}, 16'h3);
        rd(8'h01, {8'he3});
        wr(8'h01, {8'h40});
        chk({am_r, am_l, sd, ng}, 16'h4);
        rd(8'h01, {8'h42});
        wr(8'h01, {8'hc3});
        sh_r = 1'b1;
        m.tick(1);
        sh_r = 1'b0;
        rd(8'h01, {8'hd3});
        sh_l = 1'b1;
        m.tick(1);
        sh_l = 1'b0;
        rd(8'h01, {8'hdb});
        wr(8'h01, {8'hc3});
        rd(8'h01, {8'hc3});
        hot = 1'b1;
        m.tick(50);
        hot = 1'b0;
        rd(8'h01, {8'hc3});
        hot = 1'b1;
        m.tick(110);
        chk({am_r, am_l}, 16'h0);
        rd(8'h01, {8'hc7});
        hot = 1'b0;
        m.tick(3);
        chk({am_r, am_l}, 16'h3);
        rd(8'h01, {8'hc7});
        wr(8'h01, {8'hc3});
        rd(8'h01, {8'hc3});
        setidx(8'h09);
        m.stop();
        rd(8'h07, {8'h91});
        // second reset in mid-run brings back the defaults
        rst_n = 1'b0;
        m.tick(2);
        chk({am_r, am_l, sd, ng}, 16'h1);
        m.tick(18);
        rst_n = 1'b1;
        m.tick(5);
        chk({am_r, am_l, sd, ng}, 16'hd);
        rd(8'h06, {8'h3a, 8'hc2});
        wrap_up();
    end
endmodule
